/* prog_equalizer.sv */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module prog_equalizer (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// register port
	input wire logic [prog_equalizer_pkg::ADDR_W-1:0] i_addr,
	input wire logic [prog_equalizer_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [prog_equalizer_pkg::DATA_W-1:0] o_rdata,
	// neighbouring configuration
	input wire logic i_link_output_enable,
	input wire prog_equalizer_pkg::upper_taps_s i_upper_taps,
	// sample streams
	input wire prog_equalizer_pkg::sample_s i_chan_a,
	input wire prog_equalizer_pkg::sample_s i_single,
	output prog_equalizer_pkg::sample_s o_sample,
	// status
	output logic o_active,
	output logic o_merged
);
	// reset release through two flops
	logic rst_meta_n;
	logic rst_n;

	// register state
	logic [1:0] mode;
	logic [2:0] side_weight;
	logic merge;
	logic [prog_equalizer_pkg::NUM_SIDE_LOW-1:0][prog_equalizer_pkg::SIDE_W-1:0]
		low_coeff;
	logic [prog_equalizer_pkg::CENTER_W-1:0] center_coeff;
	logic [prog_equalizer_pkg::DATA_W-1:0] rdata;
	logic [1:0] next_mode;
	logic [2:0] next_side_weight;
	logic next_merge;
	logic [prog_equalizer_pkg::NUM_SIDE_LOW-1:0][prog_equalizer_pkg::SIDE_W-1:0]
		next_low_coeff;
	logic [prog_equalizer_pkg::CENTER_W-1:0] next_center_coeff;
	logic [prog_equalizer_pkg::DATA_W-1:0] next_rdata;

	// sample path state
	logic [prog_equalizer_pkg::NUM_TAPS-1:0][prog_equalizer_pkg::SAMPLE_W-1:0]
		line;
	logic [prog_equalizer_pkg::NUM_TAPS-1:0][prog_equalizer_pkg::SAMPLE_W-1:0]
		next_line;
	prog_equalizer_pkg::sample_s out_q;
	prog_equalizer_pkg::sample_s next_out;
	prog_equalizer_pkg::sample_s src;
	logic [prog_equalizer_pkg::NUM_TAPS-1:0][prog_equalizer_pkg::SIDE_W-1:0]
		side_coeff;
	logic signed [prog_equalizer_pkg::ACC_W-1:0] acc;
	logic signed [prog_equalizer_pkg::ACC_W-1:0] scaled;
	logic filter_on;

	// async assert, clocked release
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// register writes and read data; the link enable is not checked here,
	// software is trusted to quiesce the link first
	always_comb begin
		next_mode = mode;
		next_side_weight = side_weight;
		next_merge = merge;
		next_low_coeff = low_coeff;
		next_center_coeff = center_coeff;
		next_rdata = prog_equalizer_pkg::RDATA_RESET;
		if (i_wr) begin
			case (i_addr)
				prog_equalizer_pkg::CFG_ADDR: begin
					next_mode = i_wdata[prog_equalizer_pkg::MODE_MSB:
						prog_equalizer_pkg::MODE_LSB];
					// out-of-range weights clamp, never wrap
					if (i_wdata[prog_equalizer_pkg::SCW_MSB:
						prog_equalizer_pkg::SCW_LSB] >
						prog_equalizer_pkg::SCW_MAX) begin
						next_side_weight = prog_equalizer_pkg::SCW_MAX;
					end else begin
						next_side_weight = i_wdata[prog_equalizer_pkg::SCW_MSB:
							prog_equalizer_pkg::SCW_LSB];
					end
					next_merge = i_wdata[prog_equalizer_pkg::MERGE_BIT];
				end
				// ascending registers land on ascending taps
				prog_equalizer_pkg::TAP1_ADDR: begin
					next_low_coeff[0] = i_wdata[prog_equalizer_pkg::SIDE_W-1:0];
				end
				prog_equalizer_pkg::TAP2_ADDR: begin
					next_low_coeff[1] = i_wdata[prog_equalizer_pkg::SIDE_W-1:0];
				end
				prog_equalizer_pkg::TAP3_ADDR: begin
					next_low_coeff[2] = i_wdata[prog_equalizer_pkg::SIDE_W-1:0];
				end
				prog_equalizer_pkg::TAP4_ADDR: begin
					next_low_coeff[3] = i_wdata[prog_equalizer_pkg::SIDE_W-1:0];
				end
				prog_equalizer_pkg::CENTER_ADDR: begin
					next_center_coeff =
						i_wdata[prog_equalizer_pkg::CENTER_W-1:0];
				end
				default: begin
				end
			endcase
		end
		if (i_rd) begin
			case (i_addr)
				prog_equalizer_pkg::CFG_ADDR: begin
					next_rdata[prog_equalizer_pkg::MODE_MSB:
						prog_equalizer_pkg::MODE_LSB] = mode;
					next_rdata[prog_equalizer_pkg::SCW_MSB:
						prog_equalizer_pkg::SCW_LSB] = side_weight;
					next_rdata[prog_equalizer_pkg::MERGE_BIT] = merge;
				end
				prog_equalizer_pkg::STATUS_ADDR: begin
					next_rdata[prog_equalizer_pkg::STAT_ACTIVE_BIT] = filter_on;
					next_rdata[prog_equalizer_pkg::STAT_MERGED_BIT] = merge;
					next_rdata[prog_equalizer_pkg::STAT_LINK_BIT] =
						i_link_output_enable;
				end
				// reserved upper bits stay zero
				prog_equalizer_pkg::TAP1_ADDR: begin
					next_rdata[prog_equalizer_pkg::SIDE_W-1:0] = low_coeff[0];
				end
				prog_equalizer_pkg::TAP2_ADDR: begin
					next_rdata[prog_equalizer_pkg::SIDE_W-1:0] = low_coeff[1];
				end
				prog_equalizer_pkg::TAP3_ADDR: begin
					next_rdata[prog_equalizer_pkg::SIDE_W-1:0] = low_coeff[2];
				end
				prog_equalizer_pkg::TAP4_ADDR: begin
					next_rdata[prog_equalizer_pkg::SIDE_W-1:0] = low_coeff[3];
				end
				prog_equalizer_pkg::CENTER_ADDR: begin
					next_rdata[prog_equalizer_pkg::CENTER_W-1:0] =
						center_coeff;
				end
				default: begin
				end
			endcase
		end
	end

	// register state flops
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= prog_equalizer_pkg::MODE_BYPASS;
			side_weight <= prog_equalizer_pkg::SCW_RESET;
			merge <= 1'b0;
			low_coeff <= '{default: prog_equalizer_pkg::SIDE_RESET};
			center_coeff <= prog_equalizer_pkg::CENTER_RESET;
			rdata <= prog_equalizer_pkg::RDATA_RESET;
		end else begin
			mode <= next_mode;
			side_weight <= next_side_weight;
			merge <= next_merge;
			low_coeff <= next_low_coeff;
			center_coeff <= next_center_coeff;
			rdata <= next_rdata;
		end
	end

	// reserved modes behave as bypass, the safe choice
	assign filter_on = (mode == prog_equalizer_pkg::MODE_ENABLE);
	// merged filter takes the single stream instead of channel A
	assign src = merge ? i_single : i_chan_a;

	// tap order: low registers, center slot, then the upper taps
	always_comb begin
		side_coeff = '0;
		for (int i = 0; i < prog_equalizer_pkg::NUM_SIDE_LOW; i++) begin
			side_coeff[i] = low_coeff[i];
		end
		for (int i = 0; i < prog_equalizer_pkg::NUM_SIDE_HIGH; i++) begin
			side_coeff[prog_equalizer_pkg::CENTER_IDX + 1 + i] =
				i_upper_taps.coeff[i];
		end
	end

	// delay line, newest sample on tap one; products summed in units of
	// 2^-16, so the side weight is only a left shift
	always_comb begin
		next_line = line;
		next_out = out_q;
		next_out.valid = 1'b0;
		acc = '0;
		scaled = '0;
		if (src.valid) begin
			next_line[0] = src.data;
			for (int i = 1; i < prog_equalizer_pkg::NUM_TAPS; i++) begin
				next_line[i] = line[i-1];
			end
		end
		for (int i = 0; i < prog_equalizer_pkg::NUM_TAPS; i++) begin
			if (i == prog_equalizer_pkg::CENTER_IDX) begin
				acc = acc + prog_equalizer_pkg::ACC_W'(
					$signed(next_line[i]) * $signed(center_coeff));
			end else begin
				acc = acc + (prog_equalizer_pkg::ACC_W'(
					$signed(next_line[i]) * $signed(side_coeff[i]))
					<<< side_weight);
			end
		end
		scaled = acc >>> prog_equalizer_pkg::FRAC_BITS;
		// rails taken as signed; an unsigned bound would clip negative sums
		if (src.valid) begin
			next_out.valid = 1'b1;
			if (!filter_on) begin
				next_out.data = src.data;
			end else if (scaled > $signed(prog_equalizer_pkg::ACC_W'(
				{1'b0, {(prog_equalizer_pkg::SAMPLE_W-1){1'b1}}}))) begin
				// saturate rather than wrap on overload
				next_out.data = {1'b0, {(prog_equalizer_pkg::SAMPLE_W-1){1'b1}}};
			end else if (scaled < $signed(-prog_equalizer_pkg::ACC_W'(
				{1'b1, {(prog_equalizer_pkg::SAMPLE_W-1){1'b0}}}))) begin
				next_out.data = {1'b1, {(prog_equalizer_pkg::SAMPLE_W-1){1'b0}}};
			end else begin
				next_out.data = scaled[prog_equalizer_pkg::SAMPLE_W-1:0];
			end
		end
	end

	// sample path flops
	always_ff @(posedge i_core_clk or negedge rst_n) begin
		if (!rst_n) begin
			line <= '0;
			out_q <= '0;
		end else begin
			line <= next_line;
			out_q <= next_out;
		end
	end

	// outputs
	assign o_rdata = rdata;
	assign o_sample = out_q;
	assign o_active = filter_on;
	assign o_merged = merge;

	// checks
	AST_LOW_RESERVED_ZERO: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (i_rd && i_addr >= prog_equalizer_pkg::TAP1_ADDR
		&& i_addr <= prog_equalizer_pkg::TAP4_ADDR)
		|=> o_rdata[prog_equalizer_pkg::DATA_W-1:prog_equalizer_pkg::SIDE_W]
		== '0)
		else $error("reserved coefficient bits not zero");
	AST_CENTER_RESERVED_ZERO: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (i_rd && i_addr == prog_equalizer_pkg::CENTER_ADDR)
		|=> o_rdata[prog_equalizer_pkg::DATA_W-1:prog_equalizer_pkg::CENTER_W]
		== '0)
		else $error("reserved center bits not zero");
	AST_TAP2_WRITE_READ: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (i_wr && i_addr == prog_equalizer_pkg::TAP2_ADDR)
		##1 (i_rd && i_addr == prog_equalizer_pkg::TAP2_ADDR && !i_wr)
		|=> o_rdata[prog_equalizer_pkg::SIDE_W-1:0]
		== $past(i_wdata[prog_equalizer_pkg::SIDE_W-1:0], 2))
		else $error("tap two readback differs from write");
	AST_CENTER_WRITE_READ: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (i_wr && i_addr == prog_equalizer_pkg::CENTER_ADDR)
		##1 (i_rd && i_addr == prog_equalizer_pkg::CENTER_ADDR && !i_wr)
		|=> o_rdata[prog_equalizer_pkg::CENTER_W-1:0]
		== $past(i_wdata[prog_equalizer_pkg::CENTER_W-1:0], 2))
		else $error("center readback differs from write");
	AST_BYPASS_PASS: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (!filter_on && src.valid)
		|=> o_sample.valid && o_sample.data == $past(src.data))
		else $error("bypass does not pass the sample");
	AST_SIDE_WEIGHT_RANGE: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) side_weight <= prog_equalizer_pkg::SCW_MAX)
		else $error("side weight out of range");
	AST_MERGE_SOURCE: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (merge && i_single.valid)
		|=> line[0] == $past(i_single.data))
		else $error("merged stream not taken");
	AST_DUAL_SOURCE: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) (!merge && i_chan_a.valid)
		|=> line[0] == $past(i_chan_a.data))
		else $error("channel A stream not taken");
	AST_LINE_SHIFT: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) src.valid
		|=> line[prog_equalizer_pkg::CENTER_IDX]
		== $past(line[prog_equalizer_pkg::CENTER_IDX-1]))
		else $error("delay line did not shift");
	AST_OUT_LATENCY: assert property (@(posedge i_core_clk)
		disable iff (!rst_n) o_sample.valid == $past(src.valid))
		else $error("output strobe not one cycle after input");
	COV_ENABLED_OUT: cover property (@(posedge i_core_clk)
		disable iff (!rst_n) filter_on && o_sample.valid);
	COV_MERGED_OUT: cover property (@(posedge i_core_clk)
		disable iff (!rst_n) merge && filter_on && o_sample.valid);
	COV_MAX_WEIGHT: cover property (@(posedge i_core_clk)
		disable iff (!rst_n) side_weight == prog_equalizer_pkg::SCW_MAX
		&& o_sample.valid);
endmodule

/* prog_equalizer_pkg.sv */
package prog_equalizer_pkg;
	// widths of the register port and of the sample path
	localparam int ADDR_W = 12;
	localparam int DATA_W = 24;
	localparam int SAMPLE_W = 12;
	localparam int SIDE_W = 12;
	localparam int CENTER_W = 18;
	localparam int NUM_TAPS = 9;
	localparam int NUM_SIDE_LOW = 4;
	localparam int NUM_SIDE_HIGH = 4;
	localparam int CENTER_IDX = 4;
	localparam int FRAC_BITS = 16;
	localparam int ACC_W = 34;

	// register offsets
	localparam logic [ADDR_W-1:0] CFG_ADDR = 12'h400;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 12'h402;
	localparam logic [ADDR_W-1:0] TAP1_ADDR = 12'h418;
	localparam logic [ADDR_W-1:0] TAP2_ADDR = 12'h41a;
	localparam logic [ADDR_W-1:0] TAP3_ADDR = 12'h41c;
	localparam logic [ADDR_W-1:0] TAP4_ADDR = 12'h41e;
	localparam logic [ADDR_W-1:0] CENTER_ADDR = 12'h420;

	// configuration field layout
	localparam int MODE_LSB = 0;
	localparam int MODE_MSB = 1;
	localparam int SCW_LSB = 2;
	localparam int SCW_MSB = 4;
	localparam int MERGE_BIT = 5;

	// status field layout
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_MERGED_BIT = 1;
	localparam int STAT_LINK_BIT = 2;

	// field values and reset values
	localparam logic [1:0] MODE_BYPASS = 2'h0;
	localparam logic [1:0] MODE_ENABLE = 2'h2;
	localparam logic [2:0] SCW_MAX = 3'h6;
	localparam logic [2:0] SCW_RESET = 3'h0;
	localparam logic [SIDE_W-1:0] SIDE_RESET = 12'h000;
	localparam logic [CENTER_W-1:0] CENTER_RESET = 18'h00000;
	localparam logic [DATA_W-1:0] RDATA_RESET = 24'h000000;

	// one sample with its strobe
	typedef struct packed {
		logic valid;
		logic signed [SAMPLE_W-1:0] data;
	} sample_s;

	// coefficients of taps six to nine, kept by the neighbouring block
	typedef struct packed {
		logic [NUM_SIDE_HIGH-1:0][SIDE_W-1:0] coeff;
	} upper_taps_s;
endpackage

/* tb.sv */
`timescale 1ns/1ps
module tb;
	logic i_core_clk;
	logic i_arst_n;
	logic [prog_equalizer_pkg::ADDR_W-1:0] i_addr;
	logic [prog_equalizer_pkg::DATA_W-1:0] i_wdata;
	logic i_wr;
	logic i_rd;
	logic [prog_equalizer_pkg::DATA_W-1:0] o_rdata;
	logic i_link_output_enable;
	prog_equalizer_pkg::upper_taps_s i_upper_taps;
	prog_equalizer_pkg::sample_s i_chan_a;
	prog_equalizer_pkg::sample_s i_single;
	prog_equalizer_pkg::sample_s o_sample;
	logic o_active;
	logic o_merged;
	int failures;
	int checked;
	int cycles;
	int scw;
	// tap weights, tap one first; scaled so amp 1024 gives exact outputs
	int coef [9] = '{64, 128, -64, 256, 65536, 192, -128, 320, 384};

	prog_equalizer prog_equalizer_inst (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_link_output_enable(i_link_output_enable),
		.i_upper_taps(i_upper_taps), .i_chan_a(i_chan_a),
		.i_single(i_single), .o_sample(o_sample), .o_active(o_active),
		.o_merged(o_merged));

	initial begin
		i_core_clk = 1'b0;
		forever #10 i_core_clk = ~i_core_clk;
	end

	// hang guard, generous against the few hundred cycles needed
	always @(posedge i_core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end

	task automatic final_report();
		if (failures == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [23:0] seen,
			input logic [23:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// register port: strobe stands one cycle, taken at the next edge
	task automatic wr(input logic [11:0] a, input logic [23:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
	endtask

	// read data looked at only in the cycle after the strobe
	task automatic rd(input logic [11:0] a, output logic [23:0] d);
		@(posedge i_core_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	// write then read the same register with no idle cycle between strobes
	task automatic wr_rd(input logic [11:0] a, input logic [23:0] v,
			output logic [23:0] d);
		@(posedge i_core_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask

	function automatic logic [11:0] tap_addr(input int k);
		return prog_equalizer_pkg::TAP1_ADDR + 12'(2 * k);
	endfunction

	// expected output for the impulse k samples back
	function automatic logic [11:0] expect_tap(input int k, input int amp,
			input bit bypass);
		longint acc;
		if (bypass) return (k == 0) ? 12'(amp) : 12'h000;
		acc = longint'(coef[k]) * amp;
		if (k != prog_equalizer_pkg::CENTER_IDX) acc = acc <<< scw;
		acc = acc >>> 16;
		if (acc > 2047) acc = 2047;
		if (acc < -2048) acc = -2048;
		return 12'(acc);
	endfunction

	task automatic load_coeffs();
		for (int k = 0; k < 4; k++) wr(tap_addr(k), 24'(coef[k]) & 24'h000fff);
		wr(prog_equalizer_pkg::CENTER_ADDR, 24'(coef[4]) & 24'h03ffff);
		for (int j = 0; j < 4; j++) i_upper_taps.coeff[j] <= 12'(coef[5 + j]);
	endtask

	// zeros flush history, then one impulse; unselected stream carries noise
	task automatic run_impulse(input int amp, input bit merged,
			input bit bypass);
		logic [11:0] d;
		logic [23:0] seen;
		logic [23:0] e;
		for (int i = 0; i < 18; i++) begin
			@(posedge i_core_clk);
			d = (i == 8) ? 12'(amp) : 12'h000;
			i_single <= '{1'b1, merged ? d : 12'h5a5};
			i_chan_a <= '{1'b1, merged ? 12'h5a5 : d};
			#1;
			if (i >= 9) begin
				check("valid", 24'(o_sample.valid), 24'h1);
				seen = {12'h000, o_sample.data};
				e = {12'h000, expect_tap(i - 9, amp, bypass)};
				check("sample", seen, e);
			end
		end
		@(posedge i_core_clk);
		i_single.valid <= 1'b0;
		i_chan_a.valid <= 1'b0;
		@(posedge i_core_clk);
		#1;
		check("valid idle", 24'(o_sample.valid), 24'h0);
	endtask

	task automatic test_reset_and_reserved();
		logic [23:0] d;
		for (int k = 0; k < 5; k++) begin
			rd(tap_addr(k), d);
			check("reset value", d, 24'h000000);
			wr(tap_addr(k), 24'hffffff);
			rd(tap_addr(k), d);
			check("field width", d, (k == 4) ? 24'h03ffff : 24'h000fff);
		end
		wr_rd(prog_equalizer_pkg::TAP2_ADDR, 24'h000abc, d);
		check("back to back", d, 24'h000abc);
		wr_rd(prog_equalizer_pkg::CENTER_ADDR, 24'h02a5a5, d);
		check("back to back", d, 24'h02a5a5);
		wr(12'h404, 24'hffffff);
		rd(12'h404, d);
		check("unmapped", d, 24'h000000);
	endtask

	task automatic test_modes();
		logic [23:0] d;
		for (int m = 0; m < 4; m++) begin
			wr(prog_equalizer_pkg::CFG_ADDR, 24'(m));
			#1;
			check("active", 24'(o_active), 24'(m == 2));
			rd(prog_equalizer_pkg::STATUS_ADDR, d);
			check("status", d, 24'(m == 2));
		end
		wr(prog_equalizer_pkg::CFG_ADDR, 24'h000000);
		run_impulse(1024, 1'b0, 1'b1);
	endtask

	task automatic test_side_weight();
		logic [23:0] d;
		load_coeffs();
		for (int s = 0; s < 8; s += 7) begin
			wr(prog_equalizer_pkg::CFG_ADDR, 24'h000002 | 24'(s << 2));
			scw = (s > 6) ? 6 : s;
			rd(prog_equalizer_pkg::CFG_ADDR, d);
			check("cfg", d, 24'h000002 | 24'(scw << 2));
			run_impulse(1024, 1'b0, 1'b0);
		end
	endtask

	task automatic test_merge_saturate();
		logic [23:0] d;
		scw = 0;
		wr(prog_equalizer_pkg::CFG_ADDR, 24'h000022);
		// link comes up only after the settings are
		i_link_output_enable <= 1'b1;
		#1;
		check("merged", 24'(o_merged), 24'h1);
		rd(prog_equalizer_pkg::STATUS_ADDR, d);
		check("status", d, 24'h000007);
		run_impulse(1024, 1'b1, 1'b0);
		i_link_output_enable <= 1'b0;
		// largest center tap drives the result into both rails
		coef[4] = 131071;
		load_coeffs();
		run_impulse(2047, 1'b1, 1'b0);
		run_impulse(-2048, 1'b1, 1'b0);
	endtask

	initial begin
		failures = 0;
		checked = 0;
		cycles = 0;
		scw = 0;
		i_arst_n = 1'b0;
		i_addr = '0;
		i_wdata = '0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_link_output_enable = 1'b0;
		i_upper_taps = '0;
		i_chan_a = '0;
		i_single = '0;
		repeat (12) @(posedge i_core_clk);
		i_arst_n <= 1'b1;
		// internal reset copy needs two edges before the first strobe
		repeat (3) @(posedge i_core_clk);
		test_reset_and_reserved();
		test_modes();
		test_side_weight();
		test_merge_saturate();
		final_report();
	end
endmodule
